// file: mmsc_monitor_mux.v
// Monitor multiplexer select control with Avalon-MM register slave
//
// Behaviour
// - 4-bit channel select drives analog mux
// - Codes 1..A map to fixed channels
// - Buffer powered only while select nonzero
// - Select zero leaves monitor pin high-impedance
// - 4-bit discharge full scale, 300mA default
// - Battery current channels selectable in any state
// - Thermistor channels enable thermistor bias
`timescale 1ns/10ps
module mmsc_monitor_mux (
    input  wire        clock_i,
    input  wire        rst_b_i,
    // Avalon-MM slave
    input  wire [7:0]  address_i,
    input  wire        read_i,
    input  wire        write_i,
    input  wire [3:0]  byteenable_i,
    input  wire [31:0] writedata_i,
    output reg  [31:0] readdata_o,
    output reg         waitrequest_o,
    // Charger status from the charger
    input  wire        charging_flag_i,
    input  wire [3:0]  charge_state_detail_i,
    input  wire [1:0]  input_supply_detail_i,
    // Analog control
    output reg  [3:0]  channel_select_o,
    output reg         buffer_enable_o,
    output reg         monitor_output_pin_oe_b_o,
    output reg         thermistor_bias_en_o,
    output reg  [3:0]  discharge_full_scale_o,
    output reg  [5:0]  fast_charge_current_setting_o
);
`include "mmsc_map.vh"

    // Nonzero codes that name a documented channel
    function mapped_channel;
        input [3:0] sel;
        begin
            case (sel)
                `MMSC_CH_CHARGER_INPUT_V,
                `MMSC_CH_CHARGER_INPUT_I,
                `MMSC_CH_BATTERY_PIN_V,
                `MMSC_CH_BATTERY_PIN_CHG_I,
                `MMSC_CH_BATTERY_PIN_DIS_I,
                `MMSC_CH_BATTERY_PIN_DIS_NULL,
                `MMSC_CH_THM,
                `MMSC_CH_THERMISTOR_BIAS,
                `MMSC_CH_ANALOG_GROUND,
                `MMSC_CH_SYS: mapped_channel = 1'b1;
                default:      mapped_channel = 1'b0;
            endcase
        end
    endfunction

    // Thermistor node routed to the monitor pin
    function thermistor_route;
        input [3:0] sel;
        begin
            thermistor_route = (sel == `MMSC_CH_THM) || (sel == `MMSC_CH_THERMISTOR_BIAS);
        end
    endfunction

    // Bus handshake states
    localparam [0:0] ST_IDLE   = 1'b0;
    localparam [0:0] ST_ANSWER = 1'b1;

    reg         state_q;
    reg         state_d;
    reg [3:0]   sel_q;
    reg [3:0]   sel_d;
    reg [3:0]   dfs_q;
    reg [3:0]   dfs_d;
    reg [5:0]   fcc_q;
    reg [5:0]   fcc_d;
    reg [6:0]   chg_stat_q;
    reg         nulled_q;
    reg         nulled_d;
    reg [31:0]  rdata_d;
    reg         wait_d;
    wire        access;
    wire        commit;
    wire        cfg_wr;
    wire        fcc_wr;
    wire        sel_change;
    wire        settled;

    assign access = read_i | write_i;
    // Write takes effect on the edge where waitrequest is seen low
    assign commit = write_i & (state_q == ST_ANSWER);
    assign cfg_wr = commit & byteenable_i[0] & (address_i == `MMSC_OFS_MONITOR_CONFIG);
    assign fcc_wr = commit & byteenable_i[0] & (address_i == `MMSC_OFS_CHARGE_CURRENT);
    assign sel_change = cfg_wr & (writedata_i[`MMSC_SEL_MSB:`MMSC_SEL_LSB] != sel_q);

    // Two-cycle answer: wait one cycle, then answer for one cycle
    always @* begin
        state_d = ST_IDLE;
        wait_d  = 1'b1;
        case (state_q)
            ST_IDLE: begin
                if (access) begin
                    state_d = ST_ANSWER;
                    wait_d  = 1'b0;
                end
            end
            ST_ANSWER: begin
                state_d = ST_IDLE;
                wait_d  = 1'b1;
            end
            default: begin
                state_d = ST_IDLE;
                wait_d  = 1'b1;
            end
        endcase
    end

    // Read data, unmapped offsets read as zero
    always @* begin
        rdata_d = 32'h0000_0000;
        case (address_i)
            `MMSC_OFS_MONITOR_CONFIG: begin
                rdata_d[`MMSC_SEL_MSB:`MMSC_SEL_LSB] = sel_q;
                rdata_d[`MMSC_DFS_MSB:`MMSC_DFS_LSB] = dfs_q;
            end
            `MMSC_OFS_CHARGE_CURRENT: begin
                rdata_d[`MMSC_FCC_MSB:`MMSC_FCC_LSB] = fcc_q;
            end
            `MMSC_OFS_CHARGER_STATUS: begin
                rdata_d[6:0] = chg_stat_q;
            end
            `MMSC_OFS_MONITOR_STATUS: begin
                rdata_d[`MMSC_MST_BUF_BIT]      = buffer_enable_o;
                rdata_d[`MMSC_MST_BIAS_BIT]     = thermistor_bias_en_o;
                rdata_d[`MMSC_MST_SETTLED_BIT]  = settled;
                rdata_d[`MMSC_MST_UNMAPPED_BIT] = (sel_q != `MMSC_CH_OFF) & ~mapped_channel(sel_q);
                rdata_d[`MMSC_MST_NULLED_BIT]   = nulled_q;
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    // Configuration next values
    always @* begin
        sel_d = sel_q;
        dfs_d = dfs_q;
        fcc_d = fcc_q;
        if (cfg_wr) begin
            sel_d = writedata_i[`MMSC_SEL_MSB:`MMSC_SEL_LSB];
            dfs_d = writedata_i[`MMSC_DFS_MSB:`MMSC_DFS_LSB];
        end
        if (fcc_wr) begin
            fcc_d = writedata_i[`MMSC_FCC_MSB:`MMSC_FCC_LSB];
        end
    end

    // Discharge reading is offset-cancelled when picked right after a null pick, and stays so while it is rewritten
    always @* begin
        nulled_d = nulled_q;
        if (cfg_wr) begin
            if (sel_d == `MMSC_CH_BATTERY_PIN_DIS_I) begin
                nulled_d = (sel_q == `MMSC_CH_BATTERY_PIN_DIS_NULL) | (nulled_q & (sel_q == `MMSC_CH_BATTERY_PIN_DIS_I));
            end else begin
                nulled_d = 1'b0;
            end
        end
    end

    // Bus handshake registers
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q       <= ST_IDLE;
            waitrequest_o <= 1'b1;
            readdata_o    <= 32'h0000_0000;
        end else begin
            state_q       <= state_d;
            waitrequest_o <= wait_d;
            if (state_q == ST_IDLE && read_i) begin
                readdata_o <= rdata_d;
            end
        end
    end

    // Configuration and analog control registers
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sel_q                         <= `MMSC_SEL_RST;
            dfs_q                         <= `MMSC_DFS_RST;
            fcc_q                         <= `MMSC_FCC_RST;
            nulled_q                      <= 1'b0;
            channel_select_o              <= `MMSC_SEL_RST;
            buffer_enable_o               <= 1'b0;
            monitor_output_pin_oe_b_o     <= 1'b1;
            thermistor_bias_en_o          <= 1'b0;
            discharge_full_scale_o        <= `MMSC_DFS_RST;
            fast_charge_current_setting_o <= `MMSC_FCC_RST;
        end else begin
            sel_q                         <= sel_d;
            dfs_q                         <= dfs_d;
            fcc_q                         <= fcc_d;
            nulled_q                      <= nulled_d;
            // Any code routed regardless of charger state
            channel_select_o              <= sel_d;
            buffer_enable_o               <= (sel_d != `MMSC_CH_OFF);
            monitor_output_pin_oe_b_o     <= (sel_d == `MMSC_CH_OFF);
            thermistor_bias_en_o          <= thermistor_route(sel_d);
            discharge_full_scale_o        <= dfs_d;
            fast_charge_current_setting_o <= fcc_d;
        end
    end

    // Charger status mirror for the direction decode in software
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            chg_stat_q <= 7'h00;
        end else begin
            chg_stat_q[`MMSC_CST_INDET_MSB:`MMSC_CST_INDET_LSB] <= input_supply_detail_i;
            chg_stat_q[`MMSC_CST_DTLS_MSB:`MMSC_CST_DTLS_LSB]   <= charge_state_detail_i;
            chg_stat_q[`MMSC_CST_CHG_BIT]                       <= charging_flag_i;
        end
    end

    // Switching time since last select change
    mmsc_settle_timer u_settle (
        .clock_i   (clock_i),
        .rst_b_i   (rst_b_i),
        .restart_i (sel_change),
        .settled_o (settled)
    );

endmodule

// file: mmsc_map.vh
// Register offsets, field positions, reset values and timing counts of the monitor mux control
`ifndef MMSC_MAP_VH
`define MMSC_MAP_VH

// Byte offsets on the register bus
`define MMSC_OFS_MONITOR_CONFIG   8'h00
`define MMSC_OFS_CHARGE_CURRENT   8'h04
`define MMSC_OFS_CHARGER_STATUS   8'h08
`define MMSC_OFS_MONITOR_STATUS   8'h0C

// monitor_config_reg fields
`define MMSC_SEL_LSB              0
`define MMSC_SEL_MSB              3
`define MMSC_DFS_LSB              4
`define MMSC_DFS_MSB              7

// charge_current_config_reg field
`define MMSC_FCC_LSB              0
`define MMSC_FCC_MSB              5

// charger_status_reg fields
`define MMSC_CST_INDET_LSB        0
`define MMSC_CST_INDET_MSB        1
`define MMSC_CST_DTLS_LSB         2
`define MMSC_CST_DTLS_MSB         5
`define MMSC_CST_CHG_BIT          6

// monitor status bits
`define MMSC_MST_BUF_BIT          0
`define MMSC_MST_BIAS_BIT         1
`define MMSC_MST_SETTLED_BIT      2
`define MMSC_MST_UNMAPPED_BIT     3
`define MMSC_MST_NULLED_BIT       4

// Reset values
`define MMSC_SEL_RST              4'h0
`define MMSC_DFS_RST              4'h0
`define MMSC_FCC_RST              6'h00

// Channel codes
`define MMSC_CH_OFF               4'h0
`define MMSC_CH_CHARGER_INPUT_V           4'h1
`define MMSC_CH_CHARGER_INPUT_I           4'h2
`define MMSC_CH_BATTERY_PIN_V            4'h3
`define MMSC_CH_BATTERY_PIN_CHG_I        4'h4
`define MMSC_CH_BATTERY_PIN_DIS_I        4'h5
`define MMSC_CH_BATTERY_PIN_DIS_NULL     4'h6
`define MMSC_CH_THM               4'h7
`define MMSC_CH_THERMISTOR_BIAS             4'h8
`define MMSC_CH_ANALOG_GROUND              4'h9
`define MMSC_CH_SYS               4'hA

// Channel switching time, 0.3 us in 40 ns clocks rounded up
`define MMSC_SETTLE_CYCLES        4'h8

`endif

// file: mmsc_settle_timer.v
// Channel switching settle timer of the monitor mux control
`timescale 1ns/10ps
module mmsc_settle_timer (
    input  wire       clock_i,
    input  wire       rst_b_i,
    input  wire       restart_i,
    output reg        settled_o
);
`include "mmsc_map.vh"

    localparam [3:0] SETTLE_CNT = `MMSC_SETTLE_CYCLES;

    reg [3:0] count_q;

    // Restart on every select change, count up to the switching time
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_q   <= 4'h0;
            settled_o <= 1'b1;
        end else if (restart_i) begin
            count_q   <= 4'h0;
            settled_o <= 1'b0;
        end else if (!settled_o) begin
            if (count_q == SETTLE_CNT - 4'h1) begin
                settled_o <= 1'b1;
            end
            count_q <= count_q + 4'h1;
        end
    end

endmodule

// file: mmsc_monitor_mux_sva.sv
// Port assertions of the monitor mux control
`timescale 1ns/10ps
module mmsc_monitor_mux_sva (
    input wire        clock_i,
    input wire        rst_b_i,
    input wire [7:0]  address_i,
    input wire        read_i,
    input wire        write_i,
    input wire [3:0]  byteenable_i,
    input wire [31:0] writedata_i,
    input wire        waitrequest_o,
    input wire [3:0]  channel_select_o,
    input wire        buffer_enable_o,
    input wire        monitor_output_pin_oe_b_o,
    input wire        thermistor_bias_en_o,
    input wire [3:0]  discharge_full_scale_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    wire cfg_wr = write_i && !waitrequest_o && address_i == 8'h00 && byteenable_i[0];
    property p_buf; buffer_enable_o == (channel_select_o != 4'h0); endproperty
    a_buf: assert property (p_buf) else $error("buffer power wrong");
    property p_hiz; monitor_output_pin_oe_b_o == (channel_select_o == 4'h0); endproperty
    a_hiz: assert property (p_hiz) else $error("pin enable wrong");
    property p_bias;
        thermistor_bias_en_o == (channel_select_o == 4'h7 || channel_select_o == 4'h8);
    endproperty
    a_bias: assert property (p_bias) else $error("bias enable wrong");
    property p_sel; cfg_wr |=> {28'h0, channel_select_o} == ($past(writedata_i) & 32'h0000000F); endproperty
    a_sel: assert property (p_sel) else $error("select not taken");
    property p_dfs; cfg_wr |=> {24'h0, discharge_full_scale_o, 4'h0} == ($past(writedata_i) & 32'h000000F0); endproperty
    a_dfs: assert property (p_dfs) else $error("full scale not taken");
    property p_hold; !cfg_wr |=> $stable(channel_select_o); endproperty
    a_hold: assert property (p_hold) else $error("select moved without write");
    property p_wait; (read_i || write_i) && waitrequest_o |=> !waitrequest_o; endproperty
    a_wait: assert property (p_wait) else $error("no answer in one cycle");
    property p_wlow; !waitrequest_o |=> waitrequest_o; endproperty
    a_wlow: assert property (p_wlow) else $error("answer too long");
    c_bias: cover property (thermistor_bias_en_o);
    c_pin: cover property (!monitor_output_pin_oe_b_o);
    c_dis: cover property (channel_select_o == 4'h6 ##[1:16] channel_select_o == 4'h5);
endmodule
bind mmsc_monitor_mux mmsc_monitor_mux_sva chk (.*);

// file: mmsc_host_model.sv
// Host model: register bus master and measurement steps
`timescale 1ns/10ps
`include "mmsc_map.vh"
module mmsc_host_model (
    input  wire         clock_i,
    input  wire         waitrequest_i,
    input  wire  [31:0] readdata_i,
    output logic [7:0]  address_o = 8'h00,
    output logic        read_o = 1'b0,
    output logic        write_o = 1'b0,
    output logic [3:0]  byteenable_o = 4'hF,
    output logic [31:0] writedata_o = 32'h0
);
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clock_i);
        address_o <= a;
        writedata_o <= d;
        byteenable_o <= be;
        write_o <= 1'b1;
        do @(posedge clock_i); while (waitrequest_i !== 1'b0);
        write_o <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_i);
        address_o <= a;
        read_o <= 1'b1;
        do @(posedge clock_i); while (waitrequest_i !== 1'b0);
        d = readdata_i;
        read_o <= 1'b0;
    endtask
    // Select a channel, then wait the switching time before converting
    task automatic measure(input logic [3:0] code);
        wr(`MMSC_OFS_MONITOR_CONFIG, {28'h0, code}, 4'hF);
        repeat (`MMSC_SETTLE_CYCLES + 1) @(posedge clock_i);
    endtask
    task automatic park();
        wr(`MMSC_OFS_MONITOR_CONFIG, 32'h0, 4'hF);
    endtask
    function automatic logic charging(input logic f, input logic [3:0] dt, input logic [1:0] ind);
        return f && dt >= 4'h1 && dt <= 4'h7 && ind == 2'b11;
    endfunction
endmodule

// file: mmsc_monitor_mux_tb.sv
// Self-checking testbench of the monitor mux control
`timescale 1ns/10ps
`include "mmsc_map.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module mmsc_monitor_mux_tb;
    logic        clock_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        charging_flag_i = 1'b0;
    logic [3:0]  charge_state_detail_i = 4'h0;
    logic [1:0]  input_supply_detail_i = 2'h0;
    wire  [7:0]  address;
    wire         rd_en, wr_en, waitrequest, buf_en, pin_oe_b, bias_en;
    wire  [3:0]  be, sel, dfs;
    wire  [31:0] wdata, rdata_w;
    wire  [5:0]  fcc;
    logic [31:0] rdata;
    int          fails = 0;
    int          n_checks = 0;
    int          cyc = 0;
    mmsc_monitor_mux dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .address_i(address), .read_i(rd_en),
        .write_i(wr_en), .byteenable_i(be), .writedata_i(wdata), .readdata_o(rdata_w), .waitrequest_o(waitrequest),
        .charging_flag_i(charging_flag_i), .charge_state_detail_i(charge_state_detail_i),
        .input_supply_detail_i(input_supply_detail_i), .channel_select_o(sel), .buffer_enable_o(buf_en),
        .monitor_output_pin_oe_b_o(pin_oe_b), .thermistor_bias_en_o(bias_en), .discharge_full_scale_o(dfs),
        .fast_charge_current_setting_o(fcc));
    mmsc_host_model host (.clock_i(clock_i), .waitrequest_i(waitrequest), .readdata_i(rdata_w),
        .address_o(address), .read_o(rd_en), .write_o(wr_en), .byteenable_o(be), .writedata_o(wdata));
    task automatic end_of_test();
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk_out(input logic [3:0] c);
        `CHK(sel, c)
        `CHK(buf_en, c != 4'h0)
        `CHK(pin_oe_b, c == 4'h0)
        `CHK(bias_en, c == `MMSC_CH_THM || c == `MMSC_CH_THERMISTOR_BIAS)
    endtask
    initial forever #20 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            end_of_test();
        end
    end
    initial begin
        repeat (5) @(posedge clock_i);
        rst_b_i <= 1'b1;
        @(posedge clock_i);
        #1 chk_out(4'h0);
        `CHK(dfs, `MMSC_DFS_RST)
        for (int c = 0; c < 16; c++) begin
            host.wr(`MMSC_OFS_MONITOR_CONFIG, 32'(c), 4'hF);
            #1 chk_out(c[3:0]);
            host.rd(`MMSC_OFS_MONITOR_CONFIG, rdata);
            `CHK(rdata, {28'h0, c[3:0]})
            if (c == 11) begin
                host.rd(`MMSC_OFS_MONITOR_STATUS, rdata);
                `CHK(rdata, 32'h9)
            end
        end
        host.measure(`MMSC_CH_BATTERY_PIN_DIS_NULL);
        host.measure(`MMSC_CH_BATTERY_PIN_DIS_I);
        host.rd(`MMSC_OFS_MONITOR_STATUS, rdata);
        `CHK(rdata, 32'h15)
        host.park();
        host.wr(`MMSC_OFS_MONITOR_CONFIG, 32'h3, 4'hE);
        #1 chk_out(4'h0);
        host.wr(8'h10, 32'hFF, 4'hF);
        host.rd(8'h10, rdata);
        `CHK(rdata, 32'h0)
        host.wr(`MMSC_OFS_MONITOR_CONFIG, 32'hF4, 4'hF);
        #1 `CHK(dfs, 4'hF)
        chk_out(`MMSC_CH_BATTERY_PIN_CHG_I);
        host.rd(`MMSC_OFS_MONITOR_STATUS, rdata);
        `CHK(rdata, 32'h1)
        @(posedge clock_i);
        charging_flag_i <= 1'b1;
        charge_state_detail_i <= 4'h3;
        host.wr(`MMSC_OFS_CHARGE_CURRENT, 32'h2A, 4'hF);
        #1 `CHK(fcc, 6'h2A)
        for (int i = 0; i < 4; i++) begin
            @(posedge clock_i);
            input_supply_detail_i <= i[1:0];
            host.rd(`MMSC_OFS_CHARGER_STATUS, rdata);
            `CHK(rdata, {25'h0, 1'b1, 4'h3, i[1:0]})
            `CHK(host.charging(rdata[6], rdata[5:2], rdata[1:0]), i == 3)
        end
        chk_out(`MMSC_CH_BATTERY_PIN_CHG_I);
        // Reset in mid-run restores the defaults
        @(posedge clock_i);
        rst_b_i <= 1'b0;
        @(posedge clock_i);
        rst_b_i <= 1'b1;
        @(posedge clock_i);
        #1 chk_out(4'h0);
        `CHK(dfs, `MMSC_DFS_RST)
        `CHK(fcc, `MMSC_FCC_RST)
        end_of_test();
    end
endmodule
